/* rtl/ihd_cfg.svh */
`ifndef IHD_CFG_SVH
`define IHD_CFG_SVH
// fixed addresses and protocol codes
`define DA_BRIDGE_PROTOCOL_FRAME 48'h0180C2000000
`define DA_SHARED_SPANNING_TREE_FRAME 40'h01000CCCCD
`define ETH_CPU 16'h9988
`define ETH_CTAG 16'h8100
`define ETH_STAG 16'h88A8
`define ETH_LLC_MAX 16'h05DC
`define ETH_MPLS 16'h8847
`define ETH_PPPOE 16'h8864
`define ETH_IP4 16'h0800
`define ETH_IP6 16'h86DD
`define ETH_PTP 16'h88F7
`define PPP_IP4 16'h0021
`define PPP_IP6 16'h0057
`define LLC_SAP 8'hAA
`define LLC_CTRL 8'h03
`define SNAP_OUI_A 24'h000000
`define SNAP_OUI_B 24'h0000F8
`define PROTO_ICMP 8'h01
`define PROTO_IGMP 8'h02
`define PROTO_TCP 8'h06
`define PROTO_UDP 8'h11
`define PROTO_RH 8'h2B
`define RH_SRH 8'h04
// field lengths in bytes, vlan tag and mpls label limits
`define LEN_MAC 11'h006
`define LEN_ET 11'h002
`define LEN_LLC 11'h006
`define LEN_CPUTAG 11'h011
`define LEN_TCI 11'h002
`define LEN_MPLS 11'h004
`define LEN_PPPOE 11'h008
`define LEN_IP6A 11'h008
`define LEN_IP6B 11'h020
`define LEN_RH 11'h004
`define LEN_L4P 11'h004
`define LEN_L4T 11'h002
`define MAX_VLAN 2'h2
`define MAX_MPLS 2'h3
// configuration word indices, word count and reset value
`define R_CTRL 5'h00
`define R_CPU_LO 5'h01
`define R_CPU_HI 5'h02
`define R_LINK_DISCOVERY_FRAME_LO 5'h03
`define R_LINK_AGGREGATION_FRAME_LO 5'h09
`define R_LINK_AGGREGATION_FRAME_HI 5'h0A
`define R_LINK_AGGREGATION_FRAME_CPU 5'h0B
`define R_LINK_AGGREGATION_FRAME_DROP 5'h0C
`define R_ETH_A 5'h0D
`define R_ETH_B 5'h0E
`define R_ETH_C 5'h0F
`define R_PROTO 5'h10
`define R_UDP_BOOTP 5'h11
`define R_UDP_IKE 5'h12
`define R_UDP_CAPWAP 5'h13
`define R_UDP_GRE 5'h14
`define R_STATUS 5'h15
`define CFG_WORDS 21
`define CFG_RST 32'h00000000
// control word bits
`define B_BRIDGE_PROTOCOL_FRAME 0
`define B_SHARED_SPANNING_TREE_FRAME 1
`define B_CPUMAC 2
`define B_SNAP 3
`define B_LINK_DISCOVERY_FRAME 4
`define B_RH 5
`endif

/* rtl/ihd_pkg.sv */
package ihd_pkg;
  typedef enum logic [4:0] {
    ST_DA, ST_SA, ST_ET, ST_LLC, ST_CPUTAG, ST_VLAN, ST_MPLS, ST_MPLSN,
    ST_PPPOE, ST_IP4, ST_IP4B, ST_IP6, ST_SKIP, ST_RH, ST_L4, ST_L4T,
    ST_DONE
  } state_t;
  typedef enum logic [5:0] {
    CL_TRUNC, CL_BRIDGE_PROTOCOL_FRAME, CL_SHARED_SPANNING_TREE_FRAME, CL_CPUMAC, CL_LINK_AGGREGATION_FRAME, CL_LINK_DISCOVERY_FRAME, CL_LLC_BAD,
    CL_AVTP, CL_ARP, CL_RARP, CL_TS_ETH, CL_AUTH, CL_PTP, CL_MPLS_IP4,
    CL_MPLS_IP6, CL_MPLS_UNK, CL_UNKNOWN, CL_PPPOE, CL_IP4, CL_IP6,
    CL_RH_UNK, CL_AH, CL_ESP, CL_GRE, CL_SCTP, CL_TCP, CL_UDP, CL_IGMP,
    CL_ICMP, CL_BOOTP, CL_IKE, CL_CAPWAP, CL_GRE_UDP
  } class_t;
endpackage

/* rtl/ingress_header_decoder.sv */
`timescale 1ns/10ps
`include "ihd_cfg.svh"
// Contract
// - bridge protocol DA match: optional to CPU, decoding stops.
// - link-discovery criteria override the bridge protocol classification.
// - shared spanning tree DA match: optional to CPU, decoding stops.
// - enabled CPU destination MAC match steers packet to CPU.
// - DA equal to a link-discovery address continues to EtherType check.
// - link-aggregation DA: per-port to-CPU bit sends packet to CPU; with the drop bit also set the code only drops it.
// - link-aggregation DA: per-port drop bit discards packet.
// - after DA, take source MAC, then EtherType and compare.
// - EtherType up to 1500 checked as LLC/SNAP; failure ends decoding.
// - from-CPU EtherType consumes a 17 byte CPU tag, then VLANs.
// - zero to two VLAN tags, each with 2 byte control field.
// - listed terminal EtherTypes and unknown types end decoding.
// - MPLS: up to four labels, then payload nibble classified, end.
// - PPPoE continues to IPv4 or IPv6, otherwise ends.
// - unknown routing header ends if segments left, else skipped.
// - IP next protocol compared to configured and fixed L4 types.
// - UDP destination port compared against configured pairs, then end.
// - customer VLAN identifier recognised as a tag.
// - service VLAN identifier recognised as a tag.
// - CPU injected packets carry the dedicated from-CPU EtherType.
module ingress_header_decoder
  import ihd_pkg::*;
#(
  parameter int NPORT = 11
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [7:0] in_byte,
  input wire logic [4:0] in_src_port,
  input wire logic [4:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [31:0] cfg_rdata,
  output logic res_valid,
  output ihd_pkg::class_t res_class,
  output logic res_to_cpu,
  output logic res_drop
);
  import ihd_pkg::*;

  if (NPORT < 1 || NPORT > 32)
  begin : g_bad
    $error("NPORT must lie in 1..32");
  end

  logic [31:0] cfg_reg [`CFG_WORDS];
  state_t st_reg, st_next, s;
  class_t cls_reg, cls_next;
  logic [10:0] cnt_reg, cnt_next, len_reg, len_next, c, l;
  logic [47:0] acc_reg, a;
  logic [7:0] l4p_reg, l4p_next;
  logic [1:0] vlan_reg, vlan_next, mpls_reg, mpls_next;
  logic [4:0] port_reg, p;
  logic cpu_reg, cpu_next, drop_reg, drop_next;
  logic lldpda_reg, lldpda_next, bridge_protocol_frame_reg, bridge_protocol_frame_next;
  logic fdone;
  logic [15:0] pkt_cnt_reg;
  logic [2:0] link_discovery_frame_hit;
  logic [31:0] ctrl, proto;
  logic [15:0] e;

  // udp destination port against a configured pair
  function automatic logic udp_hit(logic [31:0] w, logic [15:0] dp);
    udp_hit = (dp == w[15:0]) || (dp == w[31:16]);
  endfunction

  // per-port bit; ports beyond NPORT never match
  function automatic logic port_bit(logic [31:0] v, logic [4:0] pn);
    port_bit = (32'(pn) < 32'(NPORT)) && v[pn];
  endfunction

  assign ctrl = cfg_reg[`R_CTRL];
  assign proto = cfg_reg[`R_PROTO];
  // a sop byte restarts the walk even if the last packet never ended
  assign s = in_sop ? ST_DA : st_reg;
  assign c = in_sop ? 11'h000 : cnt_reg;
  assign l = in_sop ? `LEN_MAC : len_reg;
  assign p = in_sop ? in_src_port : port_reg;
  assign a = {acc_reg[39:0], in_byte};
  assign e = a[15:0];
  assign fdone = in_valid && (c == l - 11'h001);

  for (genvar i = 0; i < 3; i++)
  begin : g_link_discovery_frame
    assign link_discovery_frame_hit[i] = a == {cfg_reg[`R_LINK_DISCOVERY_FRAME_LO + 5'(2 * i) + 5'h01][15:0],
                               cfg_reg[`R_LINK_DISCOVERY_FRAME_LO + 5'(2 * i)]};
  end

  // byte walker: each field completes on its last byte
  always_comb
  begin
    st_next = s;
    cnt_next = c + 11'h001;
    len_next = l;
    cls_next = in_sop ? CL_TRUNC : cls_reg;
    cpu_next = in_sop ? 1'b0 : cpu_reg;
    drop_next = in_sop ? 1'b0 : drop_reg;
    vlan_next = in_sop ? 2'h0 : vlan_reg;
    mpls_next = in_sop ? 2'h0 : mpls_reg;
    lldpda_next = in_sop ? 1'b0 : lldpda_reg;
    bridge_protocol_frame_next = in_sop ? 1'b0 : bridge_protocol_frame_reg;
    l4p_next = l4p_reg;
    if (fdone)
    begin
      cnt_next = 11'h000;
      st_next = ST_DONE;
      case (s)
        ST_DA:
        begin
          // bridge protocol address, unless link discovery may apply
          if (a == `DA_BRIDGE_PROTOCOL_FRAME && link_discovery_frame_hit == 3'h0)
          begin
            cls_next = CL_BRIDGE_PROTOCOL_FRAME;
            cpu_next = ctrl[`B_BRIDGE_PROTOCOL_FRAME];
          end
          else if (a[39:0] == `DA_SHARED_SPANNING_TREE_FRAME)
          begin
            cls_next = CL_SHARED_SPANNING_TREE_FRAME;
            cpu_next = ctrl[`B_SHARED_SPANNING_TREE_FRAME];
          end
          else if (ctrl[`B_CPUMAC] &&
                   a == {cfg_reg[`R_CPU_HI][15:0], cfg_reg[`R_CPU_LO]})
          begin
            cls_next = CL_CPUMAC;
            cpu_next = 1'b1;
          end
          else if (a == {cfg_reg[`R_LINK_AGGREGATION_FRAME_HI][15:0], cfg_reg[`R_LINK_AGGREGATION_FRAME_LO]})
          begin
            cls_next = CL_LINK_AGGREGATION_FRAME;
            cpu_next = port_bit(cfg_reg[`R_LINK_AGGREGATION_FRAME_CPU], p);
            drop_next = port_bit(cfg_reg[`R_LINK_AGGREGATION_FRAME_DROP], p);
          end
          else
          begin
            // carry link-discovery candidacy to the type check
            st_next = ST_SA;
            lldpda_next = link_discovery_frame_hit != 3'h0;
            bridge_protocol_frame_next = a == `DA_BRIDGE_PROTOCOL_FRAME;
          end
        end
        ST_SA, ST_CPUTAG, ST_VLAN:
        begin
          st_next = ST_ET;
          len_next = `LEN_ET;
        end
        ST_ET:
        begin
          if (e <= `ETH_LLC_MAX)
          begin
            st_next = ST_LLC;
            len_next = `LEN_LLC;
          end
          // cpu tag only ahead of any vlan tag
          else if (e == `ETH_CPU && vlan_reg == 2'h0)
          begin
            st_next = ST_CPUTAG;
            len_next = `LEN_CPUTAG;
          end
          else if ((e == `ETH_CTAG || e == `ETH_STAG) &&
                   vlan_reg != `MAX_VLAN)
          begin
            st_next = ST_VLAN;
            len_next = `LEN_TCI;
            vlan_next = vlan_reg + 2'h1;
          end
          // link discovery takes precedence over bridge protocol
          else if (lldpda_reg && e == cfg_reg[`R_ETH_A][15:0])
          begin
            cls_next = CL_LINK_DISCOVERY_FRAME;
            cpu_next = ctrl[`B_LINK_DISCOVERY_FRAME];
          end
          // bridge protocol address that failed the link_discovery_frame criteria
          else if (bridge_protocol_frame_reg)
          begin
            cls_next = CL_BRIDGE_PROTOCOL_FRAME;
            cpu_next = ctrl[`B_BRIDGE_PROTOCOL_FRAME];
          end
          else if (e == cfg_reg[`R_ETH_A][31:16])
            cls_next = CL_AVTP;
          else if (e == cfg_reg[`R_ETH_B][15:0])
            cls_next = CL_ARP;
          else if (e == cfg_reg[`R_ETH_B][31:16])
            cls_next = CL_RARP;
          else if (e == cfg_reg[`R_ETH_C][15:0])
            cls_next = CL_TS_ETH;
          else if (e == cfg_reg[`R_ETH_C][31:16])
            cls_next = CL_AUTH;
          else if (e == `ETH_PTP)
            cls_next = CL_PTP;
          else if (e == `ETH_MPLS)
          begin
            st_next = ST_MPLS;
            len_next = `LEN_MPLS;
          end
          else if (e == `ETH_PPPOE)
          begin
            st_next = ST_PPPOE;
            len_next = `LEN_PPPOE;
          end
          else if (e == `ETH_IP4)
          begin
            st_next = ST_IP4;
            len_next = 11'h001;
          end
          else if (e == `ETH_IP6)
          begin
            st_next = ST_IP6;
            len_next = `LEN_IP6A;
          end
          else
            cls_next = CL_UNKNOWN;
        end
        // llc saps and control, snap oui
        ST_LLC:
        begin
          if (a[47:40] == `LLC_SAP && a[39:32] == `LLC_SAP &&
              a[31:24] == `LLC_CTRL &&
              (a[23:0] == `SNAP_OUI_A || a[23:0] == `SNAP_OUI_B))
          begin
            st_next = ST_ET;
            len_next = `LEN_ET;
          end
          else
          begin
            cls_next = CL_LLC_BAD;
            cpu_next = ctrl[`B_SNAP];
          end
        end
        // label stack, bottom bit or fourth label ends it
        ST_MPLS:
        begin
          st_next = ST_MPLS;
          mpls_next = mpls_reg + 2'h1;
          if (a[8] || mpls_reg == `MAX_MPLS)
          begin
            st_next = ST_MPLSN;
            len_next = 11'h001;
          end
        end
        ST_MPLSN:
          if (a[7:4] == 4'h4)
            cls_next = CL_MPLS_IP4;
          else if (a[7:4] == 4'h6)
            cls_next = CL_MPLS_IP6;
          else
            cls_next = CL_MPLS_UNK;
        // inner protocol of the session header
        ST_PPPOE:
        begin
          cls_next = CL_PPPOE;
          if (e == `PPP_IP4)
          begin
            st_next = ST_IP4;
            len_next = 11'h001;
          end
          else if (e == `PPP_IP6)
          begin
            st_next = ST_IP6;
            len_next = `LEN_IP6A;
          end
        end
        // header length parked in l4p until the protocol byte
        ST_IP4:
        begin
          cls_next = CL_IP4;
          l4p_next = {4'h0, a[3:0]};
          if (a[3:0] >= 4'h5)
          begin
            st_next = ST_IP4B;
            len_next = 11'h009;
          end
        end
        ST_IP4B:
        begin
          st_next = ST_SKIP;
          l4p_next = a[7:0];
          len_next = {1'b0, l4p_reg, 2'h0} - 11'h00A;
        end
        ST_IP6:
        begin
          cls_next = CL_IP6;
          st_next = ST_SKIP;
          l4p_next = a[15:8];
          len_next = `LEN_IP6B;
        end
        // routing header: srh or exhausted ones are skipped
        ST_RH:
          if (a[15:8] == `RH_SRH || a[7:0] == 8'h00)
          begin
            st_next = ST_SKIP;
            l4p_next = a[31:24];
            len_next = {a[23:16], 3'h0} + 11'h004;
          end
          else
          begin
            cls_next = CL_RH_UNK;
            cpu_next = ctrl[`B_RH];
          end
        ST_SKIP:
          if (l4p_reg == `PROTO_RH && cls_reg == CL_IP6)
          begin
            st_next = ST_RH;
            len_next = `LEN_RH;
          end
          else if (l4p_reg == proto[7:0])
            cls_next = CL_AH;
          else if (l4p_reg == proto[15:8])
            cls_next = CL_ESP;
          else if (l4p_reg == proto[23:16])
            cls_next = CL_GRE;
          else if (l4p_reg == proto[31:24])
            cls_next = CL_SCTP;
          else if (l4p_reg == `PROTO_TCP || l4p_reg == `PROTO_UDP)
          begin
            st_next = ST_L4;
            len_next = `LEN_L4P;
            cls_next = l4p_reg == `PROTO_TCP ? CL_TCP : CL_UDP;
          end
          else if (l4p_reg == `PROTO_ICMP || l4p_reg == `PROTO_IGMP)
          begin
            st_next = ST_L4T;
            len_next = `LEN_L4T;
            cls_next = l4p_reg == `PROTO_ICMP ? CL_ICMP : CL_IGMP;
          end
        ST_L4:
          if (cls_reg == CL_UDP)
          begin
            if (udp_hit(cfg_reg[`R_UDP_BOOTP], e))
              cls_next = CL_BOOTP;
            else if (udp_hit(cfg_reg[`R_UDP_IKE], e))
              cls_next = CL_IKE;
            else if (udp_hit(cfg_reg[`R_UDP_CAPWAP], e))
              cls_next = CL_CAPWAP;
            else if (udp_hit(cfg_reg[`R_UDP_GRE], e))
              cls_next = CL_GRE_UDP;
          end
        default:
          st_next = ST_DONE;
      endcase
    end
  end

  // walker state, only moves on a valid byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= ST_DONE;
      cls_reg <= CL_TRUNC;
      cnt_reg <= 11'h000;
      len_reg <= `LEN_MAC;
      acc_reg <= 48'h000000000000;
      l4p_reg <= 8'h00;
      vlan_reg <= 2'h0;
      mpls_reg <= 2'h0;
      port_reg <= 5'h00;
      cpu_reg <= 1'b0;
      drop_reg <= 1'b0;
      lldpda_reg <= 1'b0;
      bridge_protocol_frame_reg <= 1'b0;
    end
    else if (in_valid)
    begin
      st_reg <= st_next;
      cls_reg <= cls_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      acc_reg <= a;
      l4p_reg <= l4p_next;
      vlan_reg <= vlan_next;
      mpls_reg <= mpls_next;
      port_reg <= p;
      cpu_reg <= cpu_next;
      drop_reg <= drop_next;
      lldpda_reg <= lldpda_next;
      bridge_protocol_frame_reg <= bridge_protocol_frame_next;
    end
  end

  // result one cycle after the last byte; walks cut short before any class is set report CL_TRUNC
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      res_valid <= 1'b0;
      res_class <= CL_TRUNC;
      res_to_cpu <= 1'b0;
      res_drop <= 1'b0;
      pkt_cnt_reg <= 16'h0000;
    end
    else
    begin
      res_valid <= in_valid && in_eop;
      if (in_valid && in_eop)
      begin
        res_class <= cls_next;
        res_to_cpu <= cpu_next && !drop_next;
        res_drop <= drop_next;
        pkt_cnt_reg <= pkt_cnt_reg + 16'h0001;
      end
    end
  end

  // configuration words, read live by the walker
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < `CFG_WORDS; i++)
        cfg_reg[i] <= `CFG_RST;
    end
    else if (cfg_wr && 32'(cfg_addr) < `CFG_WORDS)
      cfg_reg[cfg_addr] <= cfg_wdata;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_rdata <= 32'h00000000;
    else if (!cfg_rd)
      cfg_rdata <= 32'h00000000;
    else if (32'(cfg_addr) < `CFG_WORDS)
      cfg_rdata <= cfg_reg[cfg_addr];
    else if (cfg_addr == `R_STATUS)
      cfg_rdata <= {pkt_cnt_reg, 8'h00, res_drop, res_to_cpu, res_class};
    else
      cfg_rdata <= 32'h00000000;
  end

  a_bridge_protocol_frame_stop: assert property (@(posedge clk) disable iff (rst)
    fdone && s == ST_DA && a == `DA_BRIDGE_PROTOCOL_FRAME && link_discovery_frame_hit == 3'h0
    |=> st_reg == ST_DONE && cls_reg == CL_BRIDGE_PROTOCOL_FRAME)
    else $error("bridge_protocol_frame address did not end decoding");
  a_link_discovery_frame_over_bridge_protocol_frame: assert property (@(posedge clk) disable iff (rst)
    fdone && s == ST_DA && a == `DA_BRIDGE_PROTOCOL_FRAME && link_discovery_frame_hit != 3'h0
    |=> st_reg == ST_SA && lldpda_reg)
    else $error("link_discovery_frame candidate treated as bridge_protocol_frame");
  a_shared_spanning_tree_frame_stop: assert property (@(posedge clk) disable iff (rst)
    fdone && s == ST_DA && a != `DA_BRIDGE_PROTOCOL_FRAME && a[39:0] == `DA_SHARED_SPANNING_TREE_FRAME
    |=> cls_reg == CL_SHARED_SPANNING_TREE_FRAME && cpu_reg == $past(ctrl[`B_SHARED_SPANNING_TREE_FRAME]))
    else $error("shared_spanning_tree_frame address mishandled");
  a_link_aggregation_frame_drop: assert property (@(posedge clk) disable iff (rst)
    fdone && s == ST_DA && cls_next == CL_LINK_AGGREGATION_FRAME &&
    port_bit(cfg_reg[`R_LINK_AGGREGATION_FRAME_DROP], p)
    |=> drop_reg && st_reg == ST_DONE)
    else $error("link_aggregation_frame drop bit ignored");
  a_llc_branch: assert property (@(posedge clk) disable iff (rst)
    fdone && s == ST_ET && e <= `ETH_LLC_MAX
    |=> st_reg == ST_LLC && len_reg == `LEN_LLC)
    else $error("length type not sent to llc check");
  a_cputag_len: assert property (@(posedge clk) disable iff (rst)
    fdone && s == ST_ET && e == `ETH_CPU && vlan_reg == 2'h0
    |=> st_reg == ST_CPUTAG && len_reg == 11'h011)
    else $error("cpu tag length wrong");
  a_vlan_limit: assert property (@(posedge clk) disable iff (rst)
    vlan_reg <= 2'h2)
    else $error("more than two vlan tags");
  a_mpls_depth: assert property (@(posedge clk) disable iff (rst)
    st_reg == ST_MPLS && fdone && !in_sop && mpls_reg == 2'h3
    |=> st_reg == ST_MPLSN)
    else $error("mpls stack deeper than four");
  a_drop_wins: assert property (@(posedge clk) disable iff (rst)
    in_valid && in_eop |=> res_valid && !(res_to_cpu && res_drop))
    else $error("result late or both actions set");
endmodule

/* test/pkt_source.sv */
`timescale 1ns/10ps
// cell builder side: one packet byte per accepted clock
module pkt_source
(
  input wire logic clk,
  output logic in_valid,
  output logic in_sop,
  output logic in_eop,
  output logic [7:0] in_byte,
  output logic [4:0] in_src_port
);
  initial
  begin
    in_valid = 1'b0;
    in_sop = 1'b0;
    in_eop = 1'b0;
    in_byte = 8'h00;
    in_src_port = 5'h00;
  end
  // idle lines flip so a stale byte never passes for data
  task idle();
    @(posedge clk);
    in_valid <= 1'b0;
    in_sop <= 1'b0;
    in_eop <= 1'b0;
    in_byte <= ~in_byte;
    in_src_port <= ~in_src_port;
  endtask
  // gap idle cycles between bytes exercise a stalling builder
  task send(input logic [7:0] b[$], input logic [4:0] p, input int gap);
    for (int i = 0; i < b.size(); i++)
    begin
      if (i > 0)
        repeat (gap) idle();
      @(posedge clk);
      in_valid <= 1'b1;
      in_sop <= (i == 0);
      in_eop <= (i == b.size() - 1);
      in_byte <= b[i];
      in_src_port <= (i == 0) ? p : ~p;
    end
    idle();
  endtask
endmodule

/* test/tb_ingress_header_decoder.sv */
`timescale 1ns/10ps
`include "ihd_cfg.svh"
module tb_ingress_header_decoder;
  import ihd_pkg::*;
  typedef logic [7:0] bq_t[$];
  localparam logic [47:0] D = 48'h020000000011;
  localparam int VC = 6;
  localparam int VD = 5;
  localparam logic [36:0] CT [17] = '{{`R_CTRL, 32'h3F},
    {`R_CPU_LO, 32'h55}, {`R_CPU_HI, 32'h0200}, {`R_LINK_DISCOVERY_FRAME_LO, 32'hC2000000},
    {5'h04, 32'h0180}, {`R_LINK_AGGREGATION_FRAME_LO, 32'hC2000002}, {`R_LINK_AGGREGATION_FRAME_HI, 32'h0180},
    {`R_LINK_AGGREGATION_FRAME_CPU, 32'(VC)}, {`R_LINK_AGGREGATION_FRAME_DROP, 32'(VD)},
    {`R_ETH_A, 32'h22F088CC}, {`R_ETH_B, 32'h80350806},
    {`R_ETH_C, 32'h888E88F6}, {`R_PROTO, 32'h842F3233},
    {`R_UDP_BOOTP, 32'h00440043}, {`R_UDP_IKE, 32'h119401F4},
    {`R_UDP_CAPWAP, 32'h147F147E}, {`R_UDP_GRE, 32'h19EB12B5}};
  localparam logic [15:0] TT [7] = '{16'h0806, 16'h8035, 16'h22F0,
    16'h88F6, 16'h888E, 16'h88F7, 16'h9000};
  localparam class_t TC [7] = '{CL_ARP, CL_RARP, CL_AVTP, CL_TS_ETH,
    CL_AUTH, CL_PTP, CL_UNKNOWN};
  localparam logic [7:0] PR [7] = '{8'h33, 8'h32, 8'h2F, 8'h84, 8'h06,
    8'h02, 8'h01};
  localparam class_t PC [7] = '{CL_AH, CL_ESP, CL_GRE, CL_SCTP, CL_TCP,
    CL_IGMP, CL_ICMP};
  localparam logic [15:0] UP [5] = '{16'h0044, 16'h01F4, 16'h147E,
    16'h19EB, 16'h0007};
  localparam class_t UC [5] = '{CL_BOOTP, CL_IKE, CL_CAPWAP, CL_GRE_UDP,
    CL_UDP};
  localparam logic [7:0] NB [3] = '{8'h45, 8'h60, 8'h20};
  localparam class_t NC [3] = '{CL_MPLS_IP4, CL_MPLS_IP6, CL_MPLS_UNK};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] cfg_addr = 5'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [31:0] cfg_rdata;
  logic in_valid, in_sop, in_eop, res_valid, res_to_cpu, res_drop;
  logic [7:0] in_byte;
  logic [4:0] in_src_port;
  class_t res_class;
  logic eop_d = 1'b0;
  logic [9:0] e;
  logic [9:0] exp_q[$];
  logic [15:0] lfsr = 16'h000A;
  bq_t q;
  int n_errors = 0;
  int comparisons = 0;
  int n_pkts = 0;
  int cyc = 0;

  ingress_header_decoder ingress_header_decoder_inst (.clk(clk), .rst(rst),
    .in_valid(in_valid), .in_sop(in_sop), .in_eop(in_eop),
    .in_byte(in_byte), .in_src_port(in_src_port), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata), .res_valid(res_valid), .res_class(res_class),
    .res_to_cpu(res_to_cpu), .res_drop(res_drop));
  pkt_source pkt_source_inst (.clk(clk), .in_valid(in_valid),
    .in_sop(in_sop), .in_eop(in_eop), .in_byte(in_byte),
    .in_src_port(in_src_port));

  always #4 clk = ~clk;

  // hang guard, well above the longest expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task rd(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 check(cfg_rdata, d);
  endtask

  // model entry: class check, flag check, drop, to-cpu, class
  function automatic logic [9:0] ex(input logic cc, input logic fc,
    input logic d, input logic c, input class_t k);
    return {cc, fc, d, c, k};
  endfunction

  function automatic bq_t eth(input logic [47:0] da, input logic [15:0] t);
    bq_t b;
    b = {da[47:40], da[39:32], da[31:24], da[23:16], da[15:8], da[7:0]};
    repeat (6) b.push_back(8'(rnd()));
    b = {b, t[15:8], t[7:0]};
    return b;
  endfunction

  function automatic bq_t ip4(input bq_t b, input logic [7:0] pr);
    b = {b, 8'h45, 8'h00, 8'h00, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00};
    b = {b, 8'h40, pr};
    repeat (10) b.push_back(8'h0A);
    return b;
  endfunction

  task run(input bq_t b, input logic [9:0] x, input logic [4:0] p);
    n_pkts++;
    exp_q.push_back(x);
    pkt_source_inst.send(b, p, int'(rnd() % 2));
    repeat (2) @(posedge clk);
    check(exp_q.size(), 0);
    $display("%0t packet test done", $time);
  endtask

  // every result is matched against the queued model entry
  always @(posedge clk)
  begin
    eop_d <= in_valid && in_eop;
    if (res_valid === 1'b1)
    begin
      check(exp_q.size() > 0, 1'b1);
      e = exp_q.pop_front();
      check(eop_d, 1'b1);
      check(res_to_cpu & res_drop, 1'b0);
      if (e[9])
        check(res_class, e[5:0]);
      if (e[8])
        check({res_drop, res_to_cpu}, e[7:6]);
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (CT[i])
    begin
      wr(CT[i][36:32], CT[i][31:0]);
      rd(CT[i][36:32], CT[i][31:0]);
    end
    wr(5'h17, 32'hFFFFFFFF);
    rd(5'h17, 32'h0);
    rd(5'h16, 32'h0);
    $display("register test done");
    run(eth(`DA_BRIDGE_PROTOCOL_FRAME, 16'h1234), ex(1, 1, 0, 1, CL_BRIDGE_PROTOCOL_FRAME), 5'h3);
    run(eth(`DA_BRIDGE_PROTOCOL_FRAME, 16'h88CC), ex(1, 0, 0, 0, CL_LINK_DISCOVERY_FRAME), 5'h3);
    run(eth({8'h00, `DA_SHARED_SPANNING_TREE_FRAME}, 16'h1234), ex(1, 1, 0, 1, CL_SHARED_SPANNING_TREE_FRAME), 5'h3);
    run(eth(48'h020000000055, 16'h0806), ex(1, 1, 0, 1, CL_CPUMAC),
      5'h3);
    // link aggregation: ports 0 to 3 pick drop, cpu, both, none
    for (int p = 0; p < 4; p++)
      run(eth(48'h0180C2000002, 16'h1234),
        ex(1, 1, VD[p], VC[p] & !VD[p], CL_LINK_AGGREGATION_FRAME), 5'(p));
    for (int i = 0; i < 7; i++)
      run(eth(D, TT[i]), ex(1, 0, 0, 0, TC[i]), 5'(rnd() % 11));
    // llc at the 1500 boundary passes, a bad sap ends decoding
    q = eth(D, 16'h05DC);
    q = {q, 8'hAA, 8'hAA, 8'h03, 8'h00, 8'h00, 8'hF8, 8'h08, 8'h06};
    run(q, ex(1, 0, 0, 0, CL_ARP), 5'h1);
    q = {eth(D, 16'h002E), 8'hAA, 8'h42, 8'h03, 8'h00, 8'h00, 8'h00};
    run(q, ex(1, 1, 0, 1, CL_LLC_BAD), 5'h1);
    q = eth(D, `ETH_CPU);
    repeat (17) q.push_back(8'h5A);
    q = {q, 8'h81, 8'h00, 8'h00, 8'h05, 8'h88, 8'hA8, 8'h00, 8'h07};
    run({q, 8'h08, 8'h06}, ex(1, 0, 0, 0, CL_ARP), 5'h2);
    // a third tag is compared as a plain type
    q = {eth(D, 16'h8100), 8'h00, 8'h01, 8'h81, 8'h00, 8'h00, 8'h02};
    q = {q, 8'h81, 8'h00, 8'h00, 8'h03, 8'h08, 8'h06};
    run(q, ex(1, 0, 0, 0, CL_UNKNOWN), 5'h2);
    q = eth(D, `ETH_MPLS);
    repeat (4) q = {q, 8'h00, 8'h01, 8'h00, 8'h40};
    run({q, 8'h45}, ex(1, 0, 0, 0, CL_MPLS_IP4), 5'h2);
    for (int i = 0; i < 3; i++)
      run({eth(D, `ETH_MPLS), 8'h00, 8'h01, 8'h01, 8'h40, NB[i]},
        ex(1, 0, 0, 0, NC[i]), 5'h2);
    q = {eth(D, `ETH_PPPOE), 8'h11, 8'h00, 8'h00, 8'h01, 8'h00, 8'h20};
    run({q, 8'h00, 8'hC0}, ex(1, 0, 0, 0, CL_PPPOE), 5'h2);
    q = ip4({q, 8'h00, 8'h21}, 8'h06);
    run({q, 8'h00, 8'h50, 8'h00, 8'h50}, ex(1, 0, 0, 0, CL_TCP), 5'h2);
    for (int i = 0; i < 7; i++)
      run({ip4(eth(D, `ETH_IP4), PR[i]), 8'h00, 8'h50, 8'h00, 8'h50},
        ex(1, 0, 0, 0, PC[i]), 5'(rnd() % 11));
    for (int i = 0; i < 5; i++)
      run({ip4(eth(D, `ETH_IP4), 8'h11), 8'h12, 8'h34, UP[i][15:8],
        UP[i][7:0]},
        ex(1, 0, 0, 0, UC[i]), 5'(rnd() % 11));
    // unknown routing type: segments left ends, zero is skipped
    q = {eth(D, `ETH_IP6), 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
    q = {q, 8'h2B, 8'h40};
    repeat (32) q.push_back(8'h0B);
    run({q, 8'h11, 8'h00, 8'h07, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00},
      ex(1, 1, 0, 1, CL_RH_UNK), 5'h5);
    q = {q, 8'h11, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    run({q, 8'h12, 8'h34, 8'h00, 8'h44}, ex(1, 0, 0, 0, CL_BOOTP), 5'h5);
    // options off; bridge_protocol_frame address no longer an link_discovery_frame candidate
    wr(`R_CTRL, 32'h0);
    wr(`R_LINK_DISCOVERY_FRAME_LO, 32'hC2000001);
    run(eth({8'h00, `DA_SHARED_SPANNING_TREE_FRAME}, 16'h1234), ex(1, 1, 0, 0, CL_SHARED_SPANNING_TREE_FRAME),
      5'h3);
    run(eth(48'h020000000055, 16'h0806), ex(1, 1, 0, 0, CL_ARP),
      5'h3);
    run(eth(`DA_BRIDGE_PROTOCOL_FRAME, 16'h1234), ex(1, 1, 0, 0, CL_BRIDGE_PROTOCOL_FRAME), 5'h3);
    // status word: packet count and the last result
    rd(`R_STATUS, {16'(n_pkts), 10'h000, CL_BRIDGE_PROTOCOL_FRAME});
    end_sim();
  end
endmodule
